// ===== pkg/mqfpf_defines.vh
// constants, register map and field layout of the multi-queue port flow block
// Function
// - first word falls through one read clock later
// - deselected device floats full flag, new drives
// - filling write drops full flag, blocks writes
// - freed space raises full flag after read
// - new queue word appears two cycles after select
// - one more old-queue word after select
// - empty new queue keeps word, flag not valid
// - flag not valid cycle after last word
// - write to emptied queue outputs word, valid
// - read ownership moves data and valid drivers
// - no read enable, no change: hold word
// - output enable acts without clock
// - packet mode reads wait for complete packet
// - packet ready with or before valid flag
// - late packet ready allowed on skew violation
// - valid high while only partial packet remains
// - null queue stops reading at packet boundary
// - null queue reads as empty queue
`ifndef MQFPF_DEFINES_VH
`define MQFPF_DEFINES_VH

`define MQFPF_ADDR_W        4
`define MQFPF_REG_CTRL      4'h0
`define MQFPF_REG_STATUS    4'h4
`define MQFPF_CTRL_PKT_BIT  0
`define MQFPF_CTRL_RESET    1'h0
`define MQFPF_ST_FULL_LSB   0
`define MQFPF_ST_AVAIL_LSB  4
`define MQFPF_ST_VALID_BIT  8
`define MQFPF_ST_BUSY_BIT   9
`define MQFPF_ST_NULL_BIT   10
`define MQFPF_ST_RDQ_LSB    12
`define MQFPF_ST_WRQ_LSB    14
`define MQFPF_SEL_W         5
`define MQFPF_QSEL_W        2
`define MQFPF_DEV_W         3

`endif

// ===== rtl/mqfpf_queue.v
// one queue: flip-flop storage with write, read and packet commit pointers
`timescale 1ns/1ps
module mqfpf_queue #(
    parameter W  = 36,
    parameter AW = 4
) (
    // clock and reset
    input  wire          clock,
    input  wire          reset_n,
    // mode
    input  wire          pkt_mode,
    // fill side
    input  wire          push,
    input  wire          push_end,
    input  wire [W-1:0]  push_data,
    // drain side
    input  wire          pop,
    output wire [W-1:0]  head_data,
    output wire          can_pop,
    // status
    output wire          full_now,
    output wire          full_next
);
    reg  [W-1:0]  mem_ff [0:(1<<AW)-1];
    reg  [AW:0]   wr_ptr_ff;
    reg  [AW:0]   rd_ptr_ff;
    reg  [AW:0]   cmt_ptr_ff;
    wire [AW:0]   nxt_wr_ptr = wr_ptr_ff + {{AW{1'b0}}, push};
    wire [AW:0]   nxt_rd_ptr = rd_ptr_ff + {{AW{1'b0}}, pop};
    wire [AW:0]   cnt_now    = wr_ptr_ff - rd_ptr_ff;
    wire [AW:0]   cnt_next   = nxt_wr_ptr - nxt_rd_ptr;

    // counts are pointer differences, so full is the top count bit
    assign full_now  = cnt_now[AW];
    assign full_next = cnt_next[AW];
    // packet mode only exposes words up to the last packet end
    assign can_pop   = pkt_mode ? (cmt_ptr_ff != rd_ptr_ff)
                                : (wr_ptr_ff != rd_ptr_ff);
    assign head_data = mem_ff[rd_ptr_ff[AW-1:0]];

    always @(posedge clock)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= push_data;
        end
    end

    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            wr_ptr_ff  <= {(AW+1){1'b0}};
            rd_ptr_ff  <= {(AW+1){1'b0}};
            cmt_ptr_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            if (push && (push_end || !pkt_mode))
            begin
                cmt_ptr_ff <= nxt_wr_ptr;
            end
        end
    end
endmodule // mqfpf_queue

// ===== rtl/mqfpf_top.v
// multi-queue fifo: write port, fall-through read port, expansion flags, bus slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mqfpf_defines.vh"
module mqfpf_top #(
    parameter W  = 36,
    parameter NQ = 4,
    parameter AW = 4
) (
    // clock and reset
    input  wire                      clock,
    input  wire                      reset_n,
    // device identity in expansion
    input  wire [`MQFPF_DEV_W-1:0]   dev_id,
    // write port
    input  wire                      wr_sel,
    input  wire [`MQFPF_SEL_W-1:0]   wr_sel_addr,
    input  wire                      wr_en,
    input  wire [W-1:0]              wr_data,
    input  wire                      packet_end_marker,
    output wire                      queue_full_flag_n,
    output wire                      queue_full_flag_oe,
    // read port
    input  wire                      rd_sel,
    input  wire [`MQFPF_SEL_W-1:0]   rd_sel_addr,
    input  wire                      rd_sel_null,
    input  wire                      rd_en,
    input  wire                      out_en_n,
    output wire [W-1:0]              q_data,
    output wire                      q_data_oe,
    output wire                      output_valid_flag_n,
    output wire                      output_valid_flag_oe,
    output wire                      packet_ready_flag_n,
    // avalon-mm slave
    input  wire [`MQFPF_ADDR_W-1:0]  avs_address,
    input  wire                      avs_read,
    input  wire                      avs_write,
    input  wire [31:0]               avs_writedata,
    output wire [31:0]               avs_readdata,
    output wire                      avs_waitrequest
);
    localparam PH_IDLE   = 3'b001;
    localparam PH_DRAIN  = 3'b010;
    localparam PH_SWITCH = 3'b100;
    localparam QW        = `MQFPF_QSEL_W;

    // registers
    reg  [QW-1:0]  wr_q_ff;
    reg            wr_own_ff;
    reg            full_oe_ff;
    reg            full_n_ff;
    reg  [2:0]     phase_ff;
    reg  [2:0]     nxt_phase;
    reg  [QW-1:0]  rd_q_ff;
    reg            rd_null_ff;
    reg            rd_own_ff;
    reg  [QW-1:0]  pend_q_ff;
    reg            pend_null_ff;
    reg            pend_own_ff;
    reg            valid_ff;
    reg            nxt_valid;
    reg  [W-1:0]   q_data_ff;
    reg            ov_n_ff;
    reg            ov_oe_ff;
    reg            pr_n_ff;
    reg            pkt_mode_ff;
    reg  [31:0]    rdata_ff;
    reg            wait_ff;

    // queue interconnect
    wire [NQ*W-1:0] head_flat;
    wire [NQ-1:0]   can_pop;
    wire [NQ-1:0]   full_now;
    wire [NQ-1:0]   full_next;
    reg  [NQ-1:0]   push_vec;
    reg  [NQ-1:0]   pop_vec;
    reg  [QW-1:0]   src_q;
    reg             take;
    reg             do_pop;
    reg  [QW-1:0]   eff_q;
    reg             eff_null;
    reg  [31:0]     rd_mux;

    wire wr_accept = wr_en & wr_own_ff & full_n_ff & ~full_now[wr_q_ff];
    wire wr_sel_own = (wr_sel_addr[`MQFPF_SEL_W-1:QW] == dev_id);
    wire rd_sel_own = (rd_sel_addr[`MQFPF_SEL_W-1:QW] == dev_id);
    // selects closer than two cycles are dropped; spacing is the reader's job
    wire rd_sel_ok  = rd_sel & (phase_ff != PH_DRAIN);

    genvar gi;
    generate
        for (gi = 0; gi < NQ; gi = gi + 1)
        begin : g_queue
            mqfpf_queue #(
                .W  (W),
                .AW (AW)
            ) u_queue (
                .clock     (clock),
                .reset_n   (reset_n),
                .pkt_mode  (pkt_mode_ff),
                .push      (push_vec[gi]),
                .push_end  (packet_end_marker),
                .push_data (wr_data),
                .pop       (pop_vec[gi]),
                .head_data (head_flat[gi*W +: W]),
                .can_pop   (can_pop[gi]),
                .full_now  (full_now[gi]),
                .full_next (full_next[gi])
            );
        end
    endgenerate

    // write demux
    always @*
    begin
        push_vec = {NQ{1'b0}};
        push_vec[wr_q_ff] = wr_accept;
    end

    // read pipeline steering
    always @*
    begin
        nxt_phase = phase_ff;
        take      = 1'b0;
        do_pop    = 1'b0;
        src_q     = rd_q_ff;
        eff_q     = rd_q_ff;
        eff_null  = rd_null_ff;
        case (phase_ff)
            PH_IDLE:
            begin
                // fall-through: an invalid output loads without read enable
                take   = rd_en | ~valid_ff;
                do_pop = take & ~rd_null_ff & can_pop[rd_q_ff];
            end
            PH_DRAIN:
            begin
                // pipeline still carries one word of the old queue
                take   = 1'b1;
                do_pop = ~rd_null_ff & can_pop[rd_q_ff];
                nxt_phase = PH_SWITCH;
            end
            PH_SWITCH:
            begin
                take      = 1'b1;
                src_q     = pend_q_ff;
                eff_q     = pend_q_ff;
                eff_null  = pend_null_ff;
                do_pop    = ~pend_null_ff & can_pop[pend_q_ff];
                nxt_phase = PH_IDLE;
            end
            default:
            begin
                nxt_phase = PH_IDLE;
            end
        endcase
        if (rd_sel_ok)
        begin
            nxt_phase = PH_DRAIN;
        end
        if (do_pop)
        begin
            nxt_valid = 1'b1;
        end
        else if (take)
        begin
            nxt_valid = 1'b0;
        end
        else
        begin
            nxt_valid = valid_ff;
        end
        pop_vec = {NQ{1'b0}};
        pop_vec[src_q] = do_pop;
    end

    // write side and full flag
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            wr_q_ff    <= {QW{1'b0}};
            wr_own_ff  <= 1'b0;
            full_oe_ff <= 1'b0;
            full_n_ff  <= 1'b1;
        end
        else
        begin
            if (wr_sel)
            begin
                wr_q_ff   <= wr_sel_addr[QW-1:0];
                wr_own_ff <= wr_sel_own;
            end
            // flag follows the selected queue one cycle after the select
            full_oe_ff <= wr_own_ff;
            full_n_ff  <= ~full_next[wr_q_ff];
        end
    end

    // read side
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            phase_ff     <= PH_IDLE;
            rd_q_ff      <= {QW{1'b0}};
            rd_null_ff   <= 1'b1;
            rd_own_ff    <= 1'b0;
            pend_q_ff    <= {QW{1'b0}};
            pend_null_ff <= 1'b1;
            pend_own_ff  <= 1'b0;
            valid_ff     <= 1'b0;
            q_data_ff    <= {W{1'b0}};
            ov_n_ff      <= 1'b1;
            ov_oe_ff     <= 1'b0;
            pr_n_ff      <= 1'b1;
        end
        else
        begin
            phase_ff <= nxt_phase;
            valid_ff <= nxt_valid;
            ov_n_ff  <= ~nxt_valid;
            if (do_pop)
            begin
                q_data_ff <= head_flat[src_q*W +: W];
            end
            if (phase_ff == PH_SWITCH)
            begin
                rd_q_ff    <= pend_q_ff;
                rd_null_ff <= pend_null_ff;
                rd_own_ff  <= pend_own_ff;
                ov_oe_ff   <= pend_own_ff;
            end
            if (rd_sel_ok)
            begin
                pend_q_ff    <= rd_sel_addr[QW-1:0];
                pend_null_ff <= rd_sel_null | ~rd_sel_own;
                pend_own_ff  <= rd_sel_own;
            end
            // ready from the same count that feeds the load, so never later
            pr_n_ff <= ~(pkt_mode_ff & ~eff_null & can_pop[eff_q]);
        end
    end

    // register read mux
    always @*
    begin
        rd_mux = 32'h0;
        case (avs_address)
            `MQFPF_REG_CTRL:
            begin
                rd_mux[`MQFPF_CTRL_PKT_BIT] = pkt_mode_ff;
            end
            `MQFPF_REG_STATUS:
            begin
                rd_mux[`MQFPF_ST_FULL_LSB +: NQ]  = full_now;
                rd_mux[`MQFPF_ST_AVAIL_LSB +: NQ] = can_pop;
                rd_mux[`MQFPF_ST_VALID_BIT]       = valid_ff;
                rd_mux[`MQFPF_ST_BUSY_BIT]        = (phase_ff != PH_IDLE);
                rd_mux[`MQFPF_ST_NULL_BIT]        = rd_null_ff;
                rd_mux[`MQFPF_ST_RDQ_LSB +: QW]   = rd_q_ff;
                rd_mux[`MQFPF_ST_WRQ_LSB +: QW]   = wr_q_ff;
            end
            default:
            begin
                rd_mux = 32'h0;
            end
        endcase
    end

    // avalon slave: one wait cycle, then a single-cycle answer
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            wait_ff     <= 1'b1;
            rdata_ff    <= 32'h0;
            pkt_mode_ff <= `MQFPF_CTRL_RESET;
        end
        else
        begin
            if ((avs_read || avs_write) && wait_ff)
            begin
                wait_ff  <= 1'b0;
                rdata_ff <= rd_mux;
            end
            else
            begin
                wait_ff <= 1'b1;
            end
            if (avs_write && !wait_ff && (avs_address == `MQFPF_REG_CTRL))
            begin
                pkt_mode_ff <= avs_writedata[`MQFPF_CTRL_PKT_BIT];
            end
        end
    end

    assign queue_full_flag_n    = full_n_ff;
    assign queue_full_flag_oe   = full_oe_ff;
    assign q_data               = q_data_ff;
    // unclocked on purpose: the whole bank floats together on one pin
    assign q_data_oe            = ~out_en_n & rd_own_ff;
    assign output_valid_flag_n  = ov_n_ff;
    assign output_valid_flag_oe = ov_oe_ff;
    assign packet_ready_flag_n  = pr_n_ff;
    assign avs_readdata         = rdata_ff;
    assign avs_waitrequest      = wait_ff;
endmodule // mqfpf_top

// ===== verification/mqfpf_checker.sv
// port assertions for the multi-queue port flow block
`timescale 1ns/1ps
`include "mqfpf_defines.vh"
module mqfpf_checker #(
    parameter W = 36
) (
    // clock and reset
    input wire                     clock,
    input wire                     reset_n,
    // selects and enables
    input wire [`MQFPF_DEV_W-1:0]  dev_id,
    input wire                     wr_sel,
    input wire [`MQFPF_SEL_W-1:0]  wr_sel_addr,
    input wire                     rd_sel,
    input wire [`MQFPF_SEL_W-1:0]  rd_sel_addr,
    input wire                     rd_sel_null,
    input wire                     rd_en,
    input wire                     out_en_n,
    // outputs
    input wire [W-1:0]             q_data,
    input wire                     q_data_oe,
    input wire                     queue_full_flag_oe,
    input wire                     output_valid_flag_n,
    input wire                     output_valid_flag_oe,
    // register bus
    input wire                     avs_read,
    input wire                     avs_write,
    input wire                     avs_waitrequest
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    a_oe_async: assert property (out_en_n |-> !q_data_oe)
        else $error("data bus driven with output enable off");
    a_data_owner: assert property (!out_en_n && output_valid_flag_oe |-> q_data_oe)
        else $error("valid flag driven but data bus floating");
    a_full_own: assert property (wr_sel && wr_sel_addr[4:2] == dev_id |-> ##[1:2] queue_full_flag_oe)
        else $error("full flag not driven after own select");
    a_full_float: assert property (wr_sel && wr_sel_addr[4:2] != dev_id |-> ##[1:2] !queue_full_flag_oe)
        else $error("full flag still driven after foreign select");
    a_valid_own: assert property (rd_sel && !rd_sel_null && rd_sel_addr[4:2] == dev_id
        |-> ##3 output_valid_flag_oe)
        else $error("valid flag not driven after own read select");
    a_valid_float: assert property (rd_sel && !rd_sel_null && rd_sel_addr[4:2] != dev_id
        |-> ##3 !output_valid_flag_oe && !q_data_oe)
        else $error("read outputs driven after foreign select");
    a_word_hold: assert property (!output_valid_flag_n && !rd_en && !rd_sel
        && !$past(rd_sel) && !$past(rd_sel, 2) |=> $stable(q_data))
        else $error("output word moved without a read");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access not answered next cycle");
endmodule // mqfpf_checker

// ===== verification/mqfpf_host.sv
// host model: write stream and queue selects toward the block
`timescale 1ns/1ps
`include "mqfpf_defines.vh"
module mqfpf_host (
    // clock
    input  wire                     clock,
    // write side
    output logic                    wr_sel,
    output logic [`MQFPF_SEL_W-1:0] wr_sel_addr,
    output logic                    wr_en,
    output logic [35:0]             wr_data,
    output logic                    packet_end_marker,
    // read selects
    output logic                    rd_sel,
    output logic [`MQFPF_SEL_W-1:0] rd_sel_addr,
    output logic                    rd_sel_null
);
    initial
        {wr_sel, wr_sel_addr, wr_en, wr_data, packet_end_marker} = '0;
    initial
        {rd_sel, rd_sel_addr, rd_sel_null} = '0;
    task hsel(input logic [4:0] a);
        wr_sel      <= 1'b1;
        wr_sel_addr <= a;
        @(posedge clock);
        wr_sel      <= 1'b0;
        @(posedge clock);  // idle filler slot, no marker near the change
    endtask
    task put_n(input logic [35:0] base, input int n, input logic last);
        for (int i = 0; i < n; i++)
        begin
            wr_en             <= 1'b1;
            wr_data           <= base + 36'(i);
            packet_end_marker <= last && (i == n - 1);
            @(posedge clock);
        end
        wr_en             <= 1'b0;
        packet_end_marker <= 1'b0;
        wr_data           <= ~wr_data;  // idle bus must not look like the last word
    endtask
    task rsel(input logic [4:0] a, input logic nul);
        rd_sel      <= 1'b1;
        rd_sel_addr <= a;
        rd_sel_null <= nul;
        @(posedge clock);
        rd_sel      <= 1'b0;
        rd_sel_null <= 1'b0;
    endtask
endmodule // mqfpf_host

// ===== verification/tb.sv
// self-checking bench for the multi-queue port flow block
`timescale 1ns/1ps
module tb;
    logic        clock;
    logic        reset_n;
    logic        rd_en;
    logic        out_en_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] rdat;
    wire  [31:0] rdata;
    wire  [35:0] wr_data, q;
    wire  [4:0]  wr_sel_addr, rd_sel_addr;
    wire         wr_sel, wr_en, pkt_end, rd_sel, rd_null, wreq;
    wire         full_n, full_oe, q_oe, valid_n, valid_oe, ready_n;
    int          mismatches, n_compared, cycles;
    mqfpf_host u_host (.clock(clock), .wr_sel(wr_sel), .wr_sel_addr(wr_sel_addr),
        .wr_en(wr_en), .wr_data(wr_data), .packet_end_marker(pkt_end), .rd_sel(rd_sel),
        .rd_sel_addr(rd_sel_addr), .rd_sel_null(rd_null));
    // single device, its output enable is the shared one
    mqfpf_top u_dut (.clock(clock), .reset_n(reset_n), .dev_id(3'h1), .wr_sel(wr_sel),
        .wr_sel_addr(wr_sel_addr), .wr_en(wr_en), .wr_data(wr_data),
        .packet_end_marker(pkt_end), .queue_full_flag_n(full_n), .queue_full_flag_oe(full_oe),
        .rd_sel(rd_sel), .rd_sel_addr(rd_sel_addr), .rd_sel_null(rd_null), .rd_en(rd_en),
        .out_en_n(out_en_n), .q_data(q), .q_data_oe(q_oe), .output_valid_flag_n(valid_n),
        .output_valid_flag_oe(valid_oe), .packet_ready_flag_n(ready_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(rdata), .avs_waitrequest(wreq));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task at(input int n);
        repeat (n) @(posedge clock);
    endtask
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        at(1);
        while (wreq !== 1'b0)
            at(1);
        chk(wreq, 1'b0);
        rdat = rdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        at(1);
    endtask
    task rdchk(input logic [35:0] base, input int n);
        rd_en <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            at(1);
            chk(q, base + 36'(i));
        end
        rd_en <= 1'b0;
        at(1);
    endtask
    task s_regs;
        av(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h0);
        av(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h0000_0400);
        av(1'b1, 4'h8, 32'hffff_ffff);
        av(1'b0, 4'h8, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task s_fill;
        u_host.hsel(5'h04);
        at(1);
        chk({full_oe, full_n}, 2'b11);
        u_host.put_n(36'h100, 16, 1'b0);
        at(1);
        chk(full_n, 1'b0);
        u_host.put_n(36'hbad, 1, 1'b0);
        u_host.rsel(5'h04, 1'b0);
        at(3);
        chk({valid_n, q}, {1'b0, 36'h100});
        rdchk(36'h100, 16);
        chk({valid_n, full_n}, 2'b11);
        u_host.put_n(36'h200, 1, 1'b0);
        at(2);
        chk({valid_n, q}, {1'b0, 36'h200});
        at(3);
        chk(q, 36'h200);
    endtask
    task s_change;
        u_host.put_n(36'h300, 3, 1'b0);
        u_host.rsel(5'h05, 1'b0);  // reader takes no marker near the change
        at(2);
        chk(q, 36'h300);
        at(1);
        chk({valid_n, q}, {1'b1, 36'h300});
        u_host.rsel(5'h04, 1'b1);  // selects kept four cycles apart
        at(3);
        chk({valid_n, q}, {1'b1, 36'h300});
        u_host.rsel(5'h04, 1'b0);
        at(3);
        chk({valid_n, q}, {1'b0, 36'h301});
        out_en_n <= 1'b1;
        at(1);
        chk(q_oe, 1'b0);
        out_en_n <= 1'b0;
        at(1);
        chk(q_oe, 1'b1);
    endtask
    task s_pkt;
        av(1'b1, 4'h0, 32'h1);
        av(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h1);
        u_host.hsel(5'h06);
        u_host.rsel(5'h06, 1'b0);
        u_host.put_n(36'h400, 3, 1'b0);
        at(3);
        chk({valid_n, ready_n}, 2'b11);
        u_host.put_n(36'h403, 1, 1'b1);
        at(2);
        chk({valid_n, ready_n, q}, {2'b00, 36'h400});
        u_host.put_n(36'h500, 2, 1'b0);
        rdchk(36'h400, 4);
        chk(valid_n, 1'b1);
        av(1'b1, 4'h0, 32'h0);
    endtask
    task s_other;
        u_host.hsel(5'h08);
        at(2);
        chk(full_oe, 1'b0);
        u_host.rsel(5'h08, 1'b0);
        at(3);
        chk({valid_oe, q_oe}, 2'b00);
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize;
        end
    end
    initial
    begin
        {reset_n, rd_en, out_en_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {mismatches, n_compared, cycles} = '0;
        at(12);
        reset_n <= 1'b1;
        at(1);
        s_regs;
        s_fill;
        s_change;
        s_pkt;
        s_other;
        summarize;
    end
endmodule // tb
bind mqfpf_top mqfpf_checker #(.W(W)) u_chk (.clock(clock), .reset_n(reset_n),
    .dev_id(dev_id), .wr_sel(wr_sel), .wr_sel_addr(wr_sel_addr), .rd_sel(rd_sel),
    .rd_sel_addr(rd_sel_addr), .rd_sel_null(rd_sel_null), .rd_en(rd_en), .out_en_n(out_en_n),
    .q_data(q_data), .q_data_oe(q_data_oe), .queue_full_flag_oe(queue_full_flag_oe),
    .output_valid_flag_n(output_valid_flag_n), .output_valid_flag_oe(output_valid_flag_oe),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
